// file: lcd_shared_io_ports_test.sv
// Purpose: register and pin tests of the shared-pin ports
// Assumes: board model closes port A, bench drives port B directly
// Notes: pin reads wait out the input synchroniser
`timescale 1ns/1ps
`include "lsio_defines.svh"
module lcd_shared_io_ports_test;
   logic                sys_clk = 1'b0;
   logic                rst = 1'b1;
   logic [15:0]         reg_addr = 16'h0000;
   logic [7:0]          reg_wdata = 8'h00;
   logic                reg_wr = 1'b0;
   logic                reg_rd = 1'b0;
   logic [7:0]          reg_rdata;
   logic [3:0]          seg_sel = 4'h0;
   logic [3:0]          lcd_common = 4'h0;
   logic                adc_enable = 1'b0;
   logic [3:0]          adc_ch = 4'h0;
   lsio_pkg::lsio_pwr_t power_mode = lsio_pkg::LSIO_PWR_ACTIVE;
   logic [3:0]          pa_pull = 4'hA;
   logic [3:0]          pa_pin_in;
   logic [3:0]          pa_pin_out;
   logic [3:0]          pa_pin_oe;
   logic [7:0]          pb_pin_in = 8'h5A;
   int                  failures = 0;
   int                  n_checks = 0;

   always #20 sys_clk = ~sys_clk;

   lsio_ports i_dut
   (
      .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .segment_select_field(seg_sel), .lcd_common(lcd_common), .adc_enable(adc_enable),
      .adc_channel_select(adc_ch), .power_mode(power_mode), .pa_pin_in(pa_pin_in),
      .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pb_pin_in(pb_pin_in)
   );

   lsio_board i_board
   (
      .pa_pin_out(pa_pin_out), .pa_pin_oe(pa_pin_oe), .pa_pull(pa_pull), .pa_pin_in(pa_pin_in)
   );

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask

   task automatic pins(input logic [3:0] oe, input logic [3:0] out);
      repeat (3) @(posedge sys_clk);
      #1 check({pa_pin_oe, pa_pin_out & pa_pin_oe}, {oe, out});
   endtask

   initial
   begin
      repeat (6) @(posedge sys_clk);
      #1 check({4'h0, pa_pin_oe}, 8'h00);
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rd(`LSIO_ADDR_PA_DIR, 8'hFF);
      rd(`LSIO_ADDR_PA_DATA, 8'hFA);
      pins(4'h0, 4'h0);
      wr(`LSIO_ADDR_PA_DIR, 8'h05);
      wr(`LSIO_ADDR_PA_DATA, 8'h03);
      rd(`LSIO_ADDR_PA_DATA, 8'hFB);
      rd(`LSIO_ADDR_PA_DIR, 8'hFF);
      pins(4'h5, 4'h1);
      @(posedge sys_clk);
      pa_pull <= 4'h0;
      repeat (6) @(posedge sys_clk);
      rd(`LSIO_ADDR_PA_DATA, 8'hF1);
      for (int i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         seg_sel <= 4'h1 << i;
         lcd_common <= 4'h9 ^ 4'(i);
         pins(4'hF, 4'h9 ^ 4'(i));
      end
      @(posedge sys_clk);
      seg_sel <= 4'h0;
      pins(4'h5, 4'h1);
      @(posedge sys_clk);
      power_mode <= lsio_pkg::LSIO_PWR_SLEEP;
      wr(`LSIO_ADDR_PA_DIR, 8'h0F);
      pins(4'h5, 4'h1);
      @(posedge sys_clk);
      power_mode <= lsio_pkg::LSIO_PWR_STANDBY;
      pins(4'h0, 4'h0);
      @(posedge sys_clk);
      power_mode <= lsio_pkg::LSIO_PWR_SUBACTIVE;
      pins(4'hF, 4'h3);
      rd(`LSIO_ADDR_PB_LVL, 8'h5A);
      wr(`LSIO_ADDR_PB_LVL, 8'hFF);
      rd(`LSIO_ADDR_PB_LVL, 8'h5A);
      rd(16'h1234, `LSIO_UNMAPPED_READ);
      @(posedge sys_clk);
      adc_enable <= 1'b1;
      // channel 8 is outside port B, so nothing is masked there
      for (int i = 0; i < 9; i++)
      begin
         @(posedge sys_clk);
         adc_ch <= 4'(i);
         @(posedge sys_clk);
         rd(`LSIO_ADDR_PB_LVL, (i < 8) ? (8'h5A & ~(8'h01 << i)) : 8'h5A);
      end
      // second reset in mid-run: registers and pins back to their reset state
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 check({4'h0, pa_pin_oe}, 8'h00);
      repeat (9) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rd(`LSIO_ADDR_PA_DATA, 8'hF0);
      rd(`LSIO_ADDR_PA_DIR, 8'hFF);
      pins(4'h0, 4'h0);
      tally_and_finish;
   end

   // the sequence needs well under 1000 cycles
   initial
   begin
      #100000;
      failures++;
      tally_and_finish;
   end
endmodule

// file: lsio_board.sv
// Purpose: board model closing the port A pins
// Assumes: every port A pin has a board pull set by the bench
// Notes: no driver fights the device; undriven pins go to their pull
`timescale 1ns/1ps
module lsio_board
(
   input  wire  logic [3:0] pa_pin_out,
   input  wire  logic [3:0] pa_pin_oe,
   input  wire  logic [3:0] pa_pull,
   output logic       [3:0] pa_pin_in
);
   // released pins show the pull, never the last driven value
   always_comb
      for (int k = 0; k < 4; k++)
         pa_pin_in[k] = pa_pin_oe[k] ? pa_pin_out[k] : pa_pull[k];
endmodule

// file: lsio_defines.svh
// Purpose: constants for the shared-pin port blocks
// Assumes: 16-bit byte address, 8-bit data
// Notes: included by every design file but the package
//
// Summary of operation
// R1 - port A has four general pins, each input or output on its own
// R2 - port A data resets to F0; upper nibble reads 1 and ignores writes
// R3 - port A data read gives latched value where direction bit is 1
// R4 - port A data read gives sampled pin level where direction bit is 0
// R5 - direction bit 1 makes the pin an output, 0 an input
// R6 - direction register is write-only and always reads as all ones
// R7 - direction register resets to F0, so all port A pins are inputs
// R8 - direction and data act on a pin only in general-purpose mode
// R9 - segment select 0000 gives general pins; otherwise pin n drives common n+1
// R10 - port A floats in reset and standby, holds in sleep, runs otherwise
// R11 - port B has eight pins the device never drives
// R12 - port B data read returns current sampled pin levels on every pin not chosen as analog input
// R13 - port B pin chosen as analog input by the converter reads 0
// R14 - writes to port B data register change nothing
`ifndef LSIO_DEFINES_SVH
`define LSIO_DEFINES_SVH

`define LSIO_ADDR_PA_DATA  16'hFFDD
`define LSIO_ADDR_PB_LVL   16'hFFDE
`define LSIO_ADDR_PA_DIR   16'hFFED

`define LSIO_PA_RST        8'hF0
`define LSIO_PA_DIR_RST    8'hF0
`define LSIO_PA_FILL       4'hF
`define LSIO_DIR_READ      8'hFF
`define LSIO_UNMAPPED_READ 8'h00
`define LSIO_SEG_GPIO      4'h0
`define LSIO_ADC_CH_HI     3

`endif

// file: lsio_pin_mux.sv
// Purpose: per-pin function select of the bidirectional port
// Assumes: all inputs on sys_clk
// Notes: combinational; the caller registers the result
`timescale 1ns/1ps
`include "lsio_defines.svh"
module lsio_pin_mux
(
   input  wire  logic [3:0] seg_sel,
   input  wire  logic [3:0] dir,
   input  wire  logic [3:0] data,
   input  wire  logic [3:0] lcd_common,
   output logic       [3:0] drv_val,
   output logic       [3:0] drv_en
);

   lsio_pkg::lsio_pin_fn_t fn [4];

   // R1 four pins, each on its own
   genvar n;
   generate
      for (n = 0; n < 4; n++)
      begin : g_pin
         // R9 segment select decode
         always_comb
         begin
            if (seg_sel != `LSIO_SEG_GPIO)
               fn[n] = lsio_pkg::LSIO_FN_LCD;
            else if (dir[n])
               fn[n] = lsio_pkg::LSIO_FN_OUT;
            else
               fn[n] = lsio_pkg::LSIO_FN_IN;
         end

         // R8 gpio settings only in gpio mode
         always_comb
         begin
            case (fn[n])
               lsio_pkg::LSIO_FN_OUT:
               begin
                  drv_val[n] = data[n];
                  drv_en[n]  = 1'b1;
               end
               lsio_pkg::LSIO_FN_LCD:
               begin
                  drv_val[n] = lcd_common[n];
                  drv_en[n]  = 1'b1;
               end
               default:
               begin
                  drv_val[n] = 1'b0;
                  drv_en[n]  = 1'b0;
               end
            endcase
         end
      end
   endgenerate

endmodule

// file: lsio_pkg.sv
// Purpose: shared types of the shared-pin port blocks
// Assumes: nothing beyond the header
// Notes: no constants here, only types
package lsio_pkg;

   typedef enum logic [1:0]
   {
      LSIO_PWR_ACTIVE    = 2'b00,
      LSIO_PWR_SLEEP     = 2'b01,
      LSIO_PWR_STANDBY   = 2'b10,
      LSIO_PWR_SUBACTIVE = 2'b11
   } lsio_pwr_t;

   typedef enum logic [1:0]
   {
      LSIO_FN_IN  = 2'b00,
      LSIO_FN_OUT = 2'b01,
      LSIO_FN_LCD = 2'b10
   } lsio_pin_fn_t;

endpackage

// file: lsio_ports.sv
// Purpose: bidirectional 4-pin port with lcd commons, 8-pin input port
// Assumes: select, power and bus signals on sys_clk; pins asynchronous
// Notes: read data valid the cycle after the read strobe only
`timescale 1ns/1ps
`include "lsio_defines.svh"
module lsio_ports
(
   input  wire  logic                    sys_clk,
   input  wire  logic                    rst,
   input  wire  logic [15:0]             reg_addr,
   input  wire  logic [7:0]              reg_wdata,
   input  wire  logic                    reg_wr,
   input  wire  logic                    reg_rd,
   output logic       [7:0]              reg_rdata,
   input  wire  logic [3:0]              segment_select_field,
   input  wire  logic [3:0]              lcd_common,
   input  wire  logic                    adc_enable,
   input  wire  logic [3:0]              adc_channel_select,
   input  wire  lsio_pkg::lsio_pwr_t     power_mode,
   input  wire  logic [3:0]              pa_pin_in,
   output logic       [3:0]              pa_pin_out,
   output logic       [3:0]              pa_pin_oe,
   input  wire  logic [7:0]              pb_pin_in
);

   logic [3:0] data_q;
   logic [3:0] dir_q;
   logic [3:0] pa_lvl;
   logic [7:0] pb_lvl;
   logic [7:0] analog_mask;
   logic [7:0] pb_read;
   logic [7:0] pa_read;
   logic [3:0] drv_val;
   logic [3:0] drv_en;
   logic       hit_data;
   logic       hit_dir;
   logic       hit_pb;
   logic       run_mode;

   assign hit_data = (reg_addr == `LSIO_ADDR_PA_DATA);
   assign hit_dir  = (reg_addr == `LSIO_ADDR_PA_DIR);
   assign hit_pb   = (reg_addr == `LSIO_ADDR_PB_LVL);
   assign run_mode = (power_mode == lsio_pkg::LSIO_PWR_ACTIVE) ||
                     (power_mode == lsio_pkg::LSIO_PWR_SUBACTIVE);

   lsio_sync #(.W(4)) u_sync_a
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (pa_pin_in),
      .level_q (pa_lvl)
   );

   // R11 port b is input only, no drivers exist
   lsio_sync #(.W(8)) u_sync_b
   (
      .sys_clk (sys_clk),
      .rst     (rst),
      .pin_in  (pb_pin_in),
      .level_q (pb_lvl)
   );

   lsio_pin_mux u_mux
   (
      .seg_sel    (segment_select_field),
      .dir        (dir_q),
      .data       (data_q),
      .lcd_common (lcd_common),
      .drv_val    (drv_val),
      .drv_en     (drv_en)
   );

   // R2 only the low nibble is storage
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         data_q <= 4'(`LSIO_PA_RST);
      else if (reg_wr && hit_data)
         data_q <= reg_wdata[3:0];
   end

   // R5 direction bit 1 output, 0 input
   // R7 reset leaves every pin an input
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         dir_q <= 4'(`LSIO_PA_DIR_RST);
      else if (reg_wr && hit_dir)
         dir_q <= reg_wdata[3:0];
   end

   // R13 analog channel decode
   genvar c;
   generate
      for (c = 0; c < 8; c++)
      begin : g_an
         assign analog_mask[c] = adc_enable &&
                                 !adc_channel_select[`LSIO_ADC_CH_HI] &&
                                 (adc_channel_select[2:0] == 3'(c));
      end
   endgenerate

   // R12 live sampled levels
   // R13 analog pin forced to zero
   assign pb_read = pb_lvl & ~analog_mask;

   // R3 latched data on output bits
   // R4 pin level on input bits
   assign pa_read = {`LSIO_PA_FILL, (data_q & dir_q) | (pa_lvl & ~dir_q)};

   // R6 direction always reads ones
   // R14 port b writes fall through, nothing decodes them
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         reg_rdata <= `LSIO_UNMAPPED_READ;
      else if (reg_rd && hit_data)
         reg_rdata <= pa_read;
      else if (reg_rd && hit_dir)
         reg_rdata <= `LSIO_DIR_READ;
      else if (reg_rd && hit_pb)
         reg_rdata <= pb_read;
      else
         reg_rdata <= `LSIO_UNMAPPED_READ;
   end

   // R10 float in reset and standby, freeze in sleep
   // R9 lcd commons override direction
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pa_pin_oe  <= 4'h0;
         pa_pin_out <= 4'h0;
      end
      else if (power_mode == lsio_pkg::LSIO_PWR_STANDBY)
      begin
         pa_pin_oe  <= 4'h0;
         pa_pin_out <= 4'h0;
      end
      else if (run_mode)
      begin
         pa_pin_oe  <= drv_en;
         pa_pin_out <= drv_val;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // R7 reset values
   reset_values_a: // R7
   assert property (@(posedge sys_clk) disable iff (1'b0)
      rst |=> (dir_q == 4'h0) && (data_q == 4'h0) && (pa_pin_oe == 4'h0))
   else $error("reset values wrong");

   // R6 direction reads ones
   dir_read_ones_a: // R6
   assert property (reg_rd && hit_dir |=> reg_rdata == 8'hFF)
   else $error("direction read not all ones");

   // R2 upper nibble fixed
   data_upper_ones_a: // R2
   assert property (reg_rd && hit_data |=> reg_rdata[7:4] == 4'hF)
   else $error("data upper bits not ones");

   // R3 output bits read latch
   data_out_read_a: // R3
   assert property (reg_rd && hit_data && dir_q == 4'hF
                    |=> reg_rdata[3:0] == $past(data_q))
   else $error("output bits not read from latch");

   // R4 input bits read pins
   data_in_read_a: // R4
   assert property (reg_rd && hit_data && dir_q == 4'h0
                    |=> reg_rdata[3:0] == $past(pa_lvl))
   else $error("input bits not read from pins");

   // R5 direction write lands
   dir_write_a: // R5
   assert property (reg_wr && hit_dir ##1 !rst
                    |-> dir_q == $past(reg_wdata[3:0]))
   else $error("direction write lost");

   // R8 gpio drive follows direction
   gpio_drive_a: // R8
   assert property (run_mode && segment_select_field == 4'h0
                    |=> pa_pin_oe == $past(dir_q) &&
                        (pa_pin_out & pa_pin_oe) == ($past(data_q) & $past(dir_q)))
   else $error("gpio drive wrong");

   // R9 lcd commons driven
   lcd_drive_a: // R9
   assert property (run_mode && segment_select_field != 4'h0
                    |=> pa_pin_oe == 4'hF && pa_pin_out == $past(lcd_common))
   else $error("lcd commons not driven");

   // R10 sleep freezes pins
   sleep_hold_a: // R10
   assert property (power_mode == lsio_pkg::LSIO_PWR_SLEEP
                    |=> $stable(pa_pin_oe) && $stable(pa_pin_out))
   else $error("pins moved in sleep");

   // R10 standby floats pins
   standby_float_a: // R10
   assert property (power_mode == lsio_pkg::LSIO_PWR_STANDBY
                    |=> pa_pin_oe == 4'h0)
   else $error("pins driven in standby");

   // R12 port b read value
   pb_read_a: // R12
   assert property (reg_rd && hit_pb |=> reg_rdata == $past(pb_read))
   else $error("port b read wrong");

   // R13 analog pin reads zero
   pb_analog_zero_a: // R13
   assert property (reg_rd && hit_pb && adc_enable && !adc_channel_select[3]
                    |=> reg_rdata[$past(adc_channel_select[2:0])] == 1'b0)
   else $error("analog pin not zero");

   // R14 port b write inert
   pb_write_inert_a: // R14
   assert property (reg_wr && hit_pb
                    |=> $stable(dir_q) && $stable(data_q))
   else $error("port b write changed state");

   // R1 four pins track data when all outputs
   four_pins_a: // R1
   assert property (run_mode && segment_select_field == 4'h0 && dir_q == 4'hF
                    ##1 run_mode && segment_select_field == 4'h0 && dir_q == 4'hF
                    |=> pa_pin_out == $past(data_q))
   else $error("four-pin output mismatch");

   // R10 snapshot of the pins taken as sleep begins
   logic [3:0] sleep_oe_q;
   logic [3:0] sleep_out_q;
   logic       in_sleep_q;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         in_sleep_q <= 1'b0;
      else
         in_sleep_q <= (power_mode == lsio_pkg::LSIO_PWR_SLEEP);
   end

   // loads every cycle outside sleep, so no reset is needed
   always_ff @(posedge sys_clk)
   begin
      if (!in_sleep_q)
      begin
         sleep_oe_q  <= pa_pin_oe;
         sleep_out_q <= pa_pin_out;
      end
   end

   // R10 sleep holds for its whole length
   sleep_freeze_a: // R10
   assert property (in_sleep_q |-> pa_pin_oe == sleep_oe_q && pa_pin_out == sleep_out_q)
   else $error("pins left their sleep snapshot");

   // R2 data write lands
   data_write_a: // R2
   assert property (reg_wr && hit_data |=> data_q == $past(reg_wdata[3:0]))
   else $error("data write lost");

   // R10 standby drives no value
   standby_low_a: // R10
   assert property (power_mode == lsio_pkg::LSIO_PWR_STANDBY |=> pa_pin_out == 4'h0)
   else $error("pin value left in standby");

   // R14 port b write gives no data
   pb_write_quiet_a: // R14
   assert property (reg_wr && hit_pb |=> reg_rdata == 8'h00)
   else $error("port b write produced read data");

   // R7 pins leave reset as inputs
   reset_inputs_a: // R7
   assert property (@(posedge sys_clk) disable iff (1'b0)
      rst ##1 !rst |-> pa_pin_oe == 4'h0)
   else $error("pin driven right after reset");

   // R3 R4 R5 R9 per-pin read and drive
   genvar b;
   generate
      for (b = 0; b < 4; b++)
      begin : g_pin_chk
         bit_latch_read_a: // R3
         assert property (@(posedge sys_clk) disable iff (rst)
                          reg_rd && hit_data && dir_q[b] |=> reg_rdata[b] == $past(data_q[b]))
         else $error("output bit not read from latch");

         bit_pin_read_a: // R4
         assert property (@(posedge sys_clk) disable iff (rst)
                          reg_rd && hit_data && !dir_q[b] |=> reg_rdata[b] == $past(pa_lvl[b]))
         else $error("input bit not read from pin");

         bit_out_drive_a: // R5
         assert property (@(posedge sys_clk) disable iff (rst)
                          run_mode && segment_select_field == `LSIO_SEG_GPIO && dir_q[b]
                          |=> pa_pin_oe[b] && pa_pin_out[b] == $past(data_q[b]))
         else $error("output pin not driven from latch");

         bit_in_float_a: // R5
         assert property (@(posedge sys_clk) disable iff (rst)
                          run_mode && segment_select_field == `LSIO_SEG_GPIO && !dir_q[b]
                          |=> !pa_pin_oe[b])
         else $error("input pin driven");

         bit_lcd_drive_a: // R9
         assert property (@(posedge sys_clk) disable iff (rst)
                          run_mode && segment_select_field != `LSIO_SEG_GPIO
                          |=> pa_pin_oe[b] && pa_pin_out[b] == $past(lcd_common[b]))
         else $error("common not on its pin");
      end
   endgenerate

   // R12 R13 port b read per bit
   genvar p;
   generate
      for (p = 0; p < 8; p++)
      begin : g_pb_chk
         pb_bit_level_a: // R12
         assert property (@(posedge sys_clk) disable iff (rst)
                          reg_rd && hit_pb && !(adc_enable && adc_channel_select == 4'(p))
                          |=> reg_rdata[p] == $past(pb_lvl[p]))
         else $error("port b level not read");

         pb_bit_analog_a: // R13
         assert property (@(posedge sys_clk) disable iff (rst)
                          reg_rd && hit_pb && adc_enable && adc_channel_select == 4'(p)
                          |=> reg_rdata[p] == 1'b0)
         else $error("analog pin not read as zero");
      end
   endgenerate

   lcd_entry_c: cover property (segment_select_field == 4'h0 ##1 segment_select_field != 4'h0 ##1 pa_pin_oe == 4'hF);
   out_read_c: cover property (reg_wr && hit_dir ##1 reg_rd && hit_data);
   sleep_c: cover property (run_mode ##1 power_mode == lsio_pkg::LSIO_PWR_SLEEP [*3]);
   analog_c: cover property (reg_rd && hit_pb && analog_mask != 8'h00);
   standby_c: cover property (power_mode == lsio_pkg::LSIO_PWR_STANDBY ##1 pa_pin_oe == 4'h0);

endmodule

// file: lsio_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to sys_clk
// Notes: stage one feeds only stage two
`timescale 1ns/1ps
`include "lsio_defines.svh"
module lsio_sync
#(
   parameter int W = 8
)
(
   input  wire  logic         sys_clk,
   input  wire  logic         rst,
   input  wire  logic [W-1:0] pin_in,
   output logic       [W-1:0] level_q
);

   logic [W-1:0] meta_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   always_ff @(posedge sys_clk)
   begin
      meta_q <= pin_in;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
   end

   // a change counts only once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge sys_clk)
         begin
            if (rst)
               level_q[i] <= 1'b0;
            else if (s2_q[i] == s3_q[i])
               level_q[i] <= s3_q[i];
         end
      end
   endgenerate

endmodule
